// File: rtl/smartcard_pci_config_tail_regs.sv
`timescale 1ns/100ps
// Behaviour
// R01 - select code 0..3 reports pin 01h..04h
// R02 - any force input overrides the select bits
// R03 - tie-all set forces first line, pin 01h
// R04 - tie-all clear forces nothing, select decides
// R05 - pin register read-only, bits 7..3 zero
// R06 - minimum grant at 3Eh, resets 00h
// R07 - maximum latency at 3Fh, eeprom loadable
// R08 - capability header at 44h, resets 0001h
// R09 - next capability pointer reads 00h
// R10 - capability code reads 01h
// R11 - capabilities word at 46h, resets 7E02h
// R12 - wake-state bits 14..11 read 1111b
// R13 - version 010b or 011b per revision select
// R14 - writes to read-only bits change nothing
// R15 - force lines ranked first highest, fourth lowest
module smartcard_pci_config_tail_regs #(
  parameter int LINES = cfg_tail_pkg::IRQ_LINES
) (
  input  wire logic             clock,
  input  wire logic             rst,
  // configuration access port
  input  wire logic             cfg_req,
  input  wire logic             cfg_write,
  input  wire logic [7:0]       cfg_dword_addr,
  input  wire logic [3:0]       cfg_byte_en,
  output logic      [31:0]      cfg_rdata,
  output logic                  cfg_ack,
  // interrupt routing controls
  input  wire logic [LINES-1:0] irq_force_inputs,
  input  wire logic [1:0]       int_sel,
  input  wire logic             tie_all_irq_ctrl,
  output logic                  force_first_irq_line,
  output logic      [2:0]       irq_pin_value,
  // power-management controls
  input  wire logic             pm_revision_select,
  input  wire logic             d3cold_enable,
  // serial eeprom load of the latency bytes
  input  wire logic             eeprom_load,
  input  wire logic [7:0]       eeprom_min_grant,
  input  wire logic [7:0]       eeprom_max_latency
);

  cfg_tail_if link ();                   // carrier to the helpers

  logic [7:0]       interrupt_pin_code;  // pin register at 3Dh
  logic [7:0]       minimum_grant;       // read/update at 3Eh
  logic [7:0]       maximum_access_latency; // read/update at 3Fh
  logic [15:0]      capability_header;   // read-only at 44h
  logic [15:0]      power_mgmt_capabilities; // mixed at 46h
  logic [LINES-1:0] eff_force;           // terminals plus tie-all line
  logic [31:0]      next_rdata;          // dword picked for a read
  logic [31:0]      lane_mask;           // enabled byte lanes

  // tie-all acts on the first line only, through the flopped drive
  always_comb begin
    eff_force    = irq_force_inputs;
    eff_force[0] = irq_force_inputs[0] | force_first_irq_line; // R03
  end

  assign link.int_sel         = int_sel;
  assign link.force_lines     = eff_force[3:0];
  assign link.revision_select = pm_revision_select;
  assign link.d3cold_enable   = d3cold_enable;

  irq_pin_decoder #(
    .LINES (LINES)
  ) u_irq_pin_decoder (
    .sel (link.irq_dec)
  );

  pm_caps_word u_pm_caps_word (
    .pm (link.pm_gen)
  );

  // drive of the first force line to the core follows tie-all
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      force_first_irq_line <= 1'b0;
    end else begin
      force_first_irq_line <= tie_all_irq_ctrl; // R03 R04
    end
  end

  // pin register tracks the decoder; upper bits held at zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      interrupt_pin_code <= cfg_tail_pkg::RST_IRQ_PIN;
      irq_pin_value      <= cfg_tail_pkg::RST_IRQ_PIN[2:0];
    end else begin
      interrupt_pin_code <= {5'h00, link.pin_value}; // R05
      irq_pin_value      <= link.pin_value;          // R01
    end
  end

  // latency bytes change only by eeprom load, never by host writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      minimum_grant          <= cfg_tail_pkg::RST_MIN_GRANT; // R06
      maximum_access_latency <= cfg_tail_pkg::RST_ACCESS_LATENCY; // R07
    end else if (eeprom_load) begin
      minimum_grant          <= eeprom_min_grant;
      maximum_access_latency <= eeprom_max_latency; // R07
    end
  end

  // capability header is constant; a flop keeps the read path uniform
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capability_header <= cfg_tail_pkg::RST_CAP_HEADER; // R08
    end else begin
      capability_header <= {cfg_tail_pkg::CAP_NEXT_NONE, // R09
                            cfg_tail_pkg::CAP_CODE_PM};  // R10
    end
  end

  // capabilities word follows its controls one cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_mgmt_capabilities <= cfg_tail_pkg::RST_PM_CAPS; // R11
    end else begin
      power_mgmt_capabilities <= link.pm_word; // R12 R13
    end
  end

  // byte lanes not enabled read zero so a narrow read sees only its bytes
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      lane_mask[b*8 +: 8] = {8{cfg_byte_en[b]}};
    end
  end

  // read mux; the interrupt line byte at 3Ch lives elsewhere, reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (cfg_dword_addr == cfg_tail_pkg::DWORD_LATENCY) begin
      next_rdata[cfg_tail_pkg::OFS_IRQ_PIN[1:0]*8 +: 8]   =
        interrupt_pin_code;
      next_rdata[cfg_tail_pkg::OFS_MIN_GRANT[1:0]*8 +: 8] = minimum_grant;
      next_rdata[cfg_tail_pkg::OFS_ACCESS_LATENCY[1:0]*8 +: 8] =
        maximum_access_latency;
    end else if (cfg_dword_addr == cfg_tail_pkg::DWORD_PM) begin
      next_rdata[cfg_tail_pkg::OFS_CAP_HEADER[1:0]*8 +: 16] =
        capability_header;
      next_rdata[cfg_tail_pkg::OFS_PM_CAPS[1:0]*8 +: 16]    =
        power_mgmt_capabilities;
    end
    next_rdata = next_rdata & lane_mask;
  end

  // every request is answered next cycle; writes are acknowledged
  // and dropped, since nothing here is host-writable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= cfg_req;
      if (cfg_req && !cfg_write) begin
        cfg_rdata <= next_rdata;
      end else begin
        cfg_rdata <= 32'h0000_0000; // R14
      end
    end
  end

  // checks next to the logic

  a_pin_select: assert property ( // R01
    @(posedge clock) disable iff (rst)
    !(|eff_force) |=> interrupt_pin_code ==
      {5'h00, cfg_tail_pkg::IRQ_CODE_FIRST + {1'b0, $past(int_sel)}})
    else $error("pin code does not follow select bits");

  a_force_first: assert property ( // R02
    @(posedge clock) disable iff (rst)
    eff_force[0] |=> interrupt_pin_code == 8'h01)
    else $error("first force line not reported");

  a_force_rank: assert property ( // R15
    @(posedge clock) disable iff (rst)
    (eff_force[1] && !eff_force[0]) |=> interrupt_pin_code == 8'h02)
    else $error("force priority wrong");

  // the two lowest-ranked lines only win when every line above is quiet
  a_force_third: assert property ( // R15
    @(posedge clock) disable iff (rst)
    (eff_force[2] && eff_force[1:0] == 2'h0) |=>
      interrupt_pin_code == 8'h03)
    else $error("third force line not reported");

  a_force_fourth: assert property ( // R15
    @(posedge clock) disable iff (rst)
    (eff_force[3] && eff_force[2:0] == 3'h0) |=>
      interrupt_pin_code == 8'h04)
    else $error("fourth force line not reported");

  a_tie_all_set: assert property ( // R03
    @(posedge clock) disable iff (rst)
    tie_all_irq_ctrl |=> force_first_irq_line ##1
      interrupt_pin_code == 8'h01)
    else $error("tie-all did not force first line");

  a_tie_all_clear: assert property ( // R04
    @(posedge clock) disable iff (rst)
    !tie_all_irq_ctrl |=> !force_first_irq_line)
    else $error("force line driven without tie-all");

  a_pin_upper: assert property ( // R05
    @(posedge clock) disable iff (rst)
    interrupt_pin_code[7:3] == 5'h00 &&
      irq_pin_value == interrupt_pin_code[2:0])
    else $error("pin register upper bits set");

  // read path must carry the pin byte it held when the request was taken
  a_pin_read: assert property ( // R05
    @(posedge clock) disable iff (rst)
    (cfg_req && !cfg_write &&
      cfg_dword_addr == cfg_tail_pkg::DWORD_LATENCY && cfg_byte_en[1]) |=>
      cfg_rdata[15:8] == $past(interrupt_pin_code))
    else $error("pin byte read wrong");

  a_write_ignored: assert property ( // R14
    @(posedge clock) disable iff (rst)
    (cfg_req && cfg_write && !eeprom_load) |=>
      $stable(minimum_grant) && $stable(maximum_access_latency) &&
      cfg_rdata == 32'h0000_0000)
    else $error("write changed a read-only register");

  a_eeprom_load: assert property ( // R07
    @(posedge clock) disable iff (rst)
    eeprom_load |=> maximum_access_latency == $past(eeprom_max_latency)
      && minimum_grant == $past(eeprom_min_grant))
    else $error("eeprom load not taken");

  // only the eeprom may move the latency bytes; a stray enable would
  // let host traffic rewrite values that the bios relies on
  a_min_grant_hold: assert property ( // R06
    @(posedge clock) disable iff (rst)
    !eeprom_load |=> $stable(minimum_grant))
    else $error("minimum grant moved without a load");

  a_latency_hold: assert property ( // R07
    @(posedge clock) disable iff (rst)
    !eeprom_load |=> $stable(maximum_access_latency))
    else $error("maximum latency moved without a load");

  a_cap_read: assert property ( // R08
    @(posedge clock) disable iff (rst)
    (cfg_req && !cfg_write && cfg_dword_addr == 8'h44 &&
      cfg_byte_en == 4'hF) |=> cfg_ack && cfg_rdata[15:0] == 16'h0001)
    else $error("capability header read wrong");

  // header bytes are fixed; checked apart so a swap shows which one
  a_cap_next: assert property ( // R09
    @(posedge clock) disable iff (rst)
    capability_header[15:8] == 8'h00)
    else $error("next capability pointer not zero");

  a_cap_code: assert property ( // R10
    @(posedge clock) disable iff (rst)
    capability_header[7:0] == 8'h01)
    else $error("capability code not power management");

  a_pm_wake: assert property ( // R12
    @(posedge clock) disable iff (rst)
    power_mgmt_capabilities[14:11] == 4'hF)
    else $error("wake-state bits not all set");

  // fixed fields of the capabilities word around the live ones
  a_pm_fixed: assert property ( // R11
    @(posedge clock) disable iff (rst)
    power_mgmt_capabilities[10:9] == 2'h3 &&
      power_mgmt_capabilities[5:3] == 3'h0)
    else $error("fixed capability bits wrong");

  // aux current claimed only alongside wake from d3cold
  a_pm_d3cold: assert property ( // R11
    @(posedge clock) disable iff (rst)
    d3cold_enable |=> power_mgmt_capabilities[15] &&
      power_mgmt_capabilities[8:6] == 3'h1)
    else $error("d3cold support not reported");

  a_pm_self_powered: assert property ( // R11
    @(posedge clock) disable iff (rst)
    !d3cold_enable |=> !power_mgmt_capabilities[15] &&
      power_mgmt_capabilities[8:6] == 3'h0)
    else $error("aux current claimed without d3cold");

  a_pm_revision: assert property ( // R13
    @(posedge clock) disable iff (rst)
    pm_revision_select |=> power_mgmt_capabilities[2:0] == 3'h3)
    else $error("version not 011b with revision select");

  a_pm_revision_old: assert property ( // R13
    @(posedge clock) disable iff (rst)
    !pm_revision_select |=> power_mgmt_capabilities[2:0] == 3'h2)
    else $error("version not 010b without revision select");

  a_read_answer: assert property ( // request acknowledged next cycle
    @(posedge clock) disable iff (rst)
    cfg_req |=> cfg_ack ##1 !cfg_ack || $past(cfg_req))
    else $error("request not answered next cycle");

endmodule : smartcard_pci_config_tail_regs

// File: rtl/cfg_tail_pkg.sv
package cfg_tail_pkg;

  // dword addresses of the two configuration words this block answers
  localparam logic [7:0]  DWORD_LATENCY   = 8'h3C; // bytes 3Ch..3Fh
  localparam logic [7:0]  DWORD_PM        = 8'h44; // bytes 44h..47h

  // byte offsets of the registers held here
  localparam logic [7:0]  OFS_IRQ_PIN     = 8'h3D;
  localparam logic [7:0]  OFS_MIN_GRANT   = 8'h3E;
  localparam logic [7:0]  OFS_ACCESS_LATENCY = 8'h3F;
  localparam logic [7:0]  OFS_CAP_HEADER  = 8'h44;
  localparam logic [7:0]  OFS_PM_CAPS     = 8'h46;

  // reset values
  localparam logic [7:0]  RST_IRQ_PIN     = 8'h01;
  localparam logic [7:0]  RST_MIN_GRANT   = 8'h00;
  localparam logic [7:0]  RST_ACCESS_LATENCY = 8'h00;
  localparam logic [15:0] RST_CAP_HEADER  = 16'h0001;
  localparam logic [15:0] RST_PM_CAPS     = 16'h7E02;

  // capability header bytes
  localparam logic [7:0]  CAP_CODE_PM     = 8'h01;
  localparam logic [7:0]  CAP_NEXT_NONE   = 8'h00;

  // interrupt pin encoding: line a is code 1, then upward
  localparam logic [2:0]  IRQ_CODE_FIRST  = 3'h1;
  localparam int          IRQ_LINES       = 4;

  // power-management capabilities field values
  localparam int          PM_D3COLD_BIT   = 15;
  localparam int          PM_WAKE_LO      = 11;
  localparam int          PM_VER_HI       = 2;
  localparam logic [3:0]  PM_WAKE_STATES  = 4'hF; // d3hot, d2, d1, d0
  localparam logic [1:0]  PM_D2_D1        = 2'h3;
  localparam logic [2:0]  PM_AUX_SELF     = 3'h0;
  localparam logic [2:0]  PM_AUX_55MA     = 3'h1;
  localparam logic [2:0]  PM_LOW_FLAGS    = 3'h0; // dsi, reserved, clock
  localparam logic [2:0]  PM_VER_REV11    = 3'h2;
  localparam logic [2:0]  PM_VER_REV12    = 3'h3;

endpackage : cfg_tail_pkg

// File: rtl/cfg_tail_if.sv
`timescale 1ns/100ps
// carries the select, force and capability values between the blocks
interface cfg_tail_if;
  logic [1:0]  int_sel;          // interrupt select bits
  logic [3:0]  force_lines;      // effective force inputs, bit 0 = line a
  logic [2:0]  pin_value;        // decoded pin code
  logic        revision_select;  // pick newer power-management revision
  logic        d3cold_enable;    // wake from d3cold supported
  logic [15:0] pm_word;          // assembled capabilities word

  modport irq_dec (input int_sel, input force_lines, output pin_value);
  modport pm_gen  (input revision_select, input d3cold_enable,
                   output pm_word);
  modport core    (output int_sel, output force_lines,
                   output revision_select, output d3cold_enable,
                   input pin_value, input pm_word);
endinterface : cfg_tail_if

// File: rtl/irq_pin_decoder.sv
`timescale 1ns/100ps
// turns select bits and force lines into the interrupt pin code
module irq_pin_decoder #(
  parameter int LINES = cfg_tail_pkg::IRQ_LINES
) (
  cfg_tail_if.irq_dec sel
);

  // lowest index wins, so scan downward and let line a land last
  always_comb begin
    sel.pin_value = cfg_tail_pkg::IRQ_CODE_FIRST + {1'b0, sel.int_sel}; // R01
    for (int i = LINES - 1; i >= 0; i--) begin
      if (sel.force_lines[i]) begin // R02
        sel.pin_value = 3'(i + 1); // R15
      end
    end
  end

endmodule : irq_pin_decoder

// File: rtl/pm_caps_word.sv
`timescale 1ns/100ps
// builds the power-management capabilities word from its controls
module pm_caps_word (
  cfg_tail_if.pm_gen pm
);

  logic [2:0] aux_current; // auxiliary current field
  logic [2:0] version;     // spec revision field

  // aux current only claimed when wake from d3cold is offered
  always_comb begin
    aux_current = pm.d3cold_enable ? cfg_tail_pkg::PM_AUX_55MA
                                   : cfg_tail_pkg::PM_AUX_SELF;
    version     = pm.revision_select ? cfg_tail_pkg::PM_VER_REV12 // R13
                                     : cfg_tail_pkg::PM_VER_REV11;
    pm.pm_word  = {pm.d3cold_enable,
                   cfg_tail_pkg::PM_WAKE_STATES, // R12
                   cfg_tail_pkg::PM_D2_D1,
                   aux_current,
                   cfg_tail_pkg::PM_LOW_FLAGS,
                   version};
  end

endmodule : pm_caps_word

// File: bench/cfg_host_model.sv
`timescale 1ns/100ps
// behavioural host that issues configuration accesses one at a time
module cfg_host_model (
  input  wire logic        clock,
  output logic             cfg_req,
  output logic             cfg_write,
  output logic [7:0]       cfg_dword_addr,
  output logic [3:0]       cfg_byte_en,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack
);
  // idle lines start with a pattern, never a plausible request
  initial begin
    cfg_req        = 1'b0;
    cfg_write      = 1'b0;
    cfg_dword_addr = 8'hA5;
    cfg_byte_en    = 4'h0;
  end

  // one access: request held for a single edge, then a bounded wait
  task automatic access(input logic wr, input logic [7:0] addr,
                        input logic [3:0] be, output logic [31:0] data,
                        output logic acked);
    data  = '1;
    acked = 1'b0;
    @(posedge clock);
    #1;
    cfg_req        = 1'b1;
    cfg_write      = wr;
    cfg_dword_addr = addr;
    cfg_byte_en    = be;
    @(posedge clock);
    #1;
    cfg_req        = 1'b0;
    // released lines show the inverse so stale values cannot pass
    cfg_write      = ~wr;
    cfg_dword_addr = ~addr;
    cfg_byte_en    = ~be;
    for (int i = 0; i < 4 && !acked; i++) begin
      @(posedge clock);
      if (cfg_ack === 1'b1) begin
        acked = 1'b1;
        data  = cfg_rdata;
      end
    end
  endtask : access
endmodule : cfg_host_model

// File: bench/smartcard_pci_config_tail_regs_tb.sv
`timescale 1ns/100ps
// register-level checks of the configuration tail block
module smartcard_pci_config_tail_regs_tb;
  logic        clock = 1'b0;           // 100 MHz
  logic        rst = 1'b1;             // async, active high
  logic        cfg_req, cfg_write, cfg_ack;
  logic [7:0]  cfg_dword_addr;
  logic [3:0]  cfg_byte_en, irq_force_inputs = 4'h0;
  logic [31:0] cfg_rdata;
  logic [1:0]  int_sel = 2'h0;
  logic        tie_all_irq_ctrl = 1'b0, force_first_irq_line;
  logic [2:0]  irq_pin_value;
  logic        pm_revision_select = 1'b0, d3cold_enable = 1'b0;
  logic        eeprom_load = 1'b0;
  logic [7:0]  eeprom_min_grant = 8'h00, eeprom_max_latency = 8'h00;
  int          errors = 0, n_compared = 0, cycles = 0;
  logic [2:0]  p;

  always #5 clock = ~clock;

  smartcard_pci_config_tail_regs i_dut (.clock(clock), .rst(rst),
    .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_dword_addr(cfg_dword_addr), .cfg_byte_en(cfg_byte_en),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .irq_force_inputs(irq_force_inputs), .int_sel(int_sel),
    .tie_all_irq_ctrl(tie_all_irq_ctrl),
    .force_first_irq_line(force_first_irq_line),
    .irq_pin_value(irq_pin_value),
    .pm_revision_select(pm_revision_select),
    .d3cold_enable(d3cold_enable), .eeprom_load(eeprom_load),
    .eeprom_min_grant(eeprom_min_grant),
    .eeprom_max_latency(eeprom_max_latency));

  cfg_host_model i_host (.clock(clock), .cfg_req(cfg_req),
    .cfg_write(cfg_write), .cfg_dword_addr(cfg_dword_addr),
    .cfg_byte_en(cfg_byte_en), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // access plus compare; a missing ack counts as a mismatch too
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] exp);
    logic [31:0] d;
    logic        k;
    i_host.access(wr, a, be, d, k);
    check({31'h0, k}, 32'h1);
    check(d, exp);
  endtask : xfer

  // let n edges pass, then step just past the edge to drive inputs
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // expected capabilities word from the two controls
  function automatic logic [15:0] pm(input logic d3, input logic rv);
    return {d3, 4'hF, 2'h3, 2'h0, d3, 3'h0, 2'h1, rv};
  endfunction : pm

  task automatic complete_run();
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial begin
    step(10);
    rst = 1'b0;
    xfer(1'b0, 8'h3C, 4'hF, 32'h0000_0100);
    xfer(1'b0, 8'h44, 4'hF, 32'h7E02_0001);
    xfer(1'b0, 8'h44, 4'h3, 32'h0000_0001);
    // select code decides when nothing forces a line
    for (int s = 0; s < 4; s++) begin
      step(1);
      int_sel = 2'(s);
      step(3);
      xfer(1'b0, 8'h3C, 4'h2, {16'h0, 5'h0, 3'(s + 1), 8'h00});
      check({29'h0, irq_pin_value}, 32'(s + 1));
    end
    // every force pattern, select parked at the last line
    for (int f = 1; f < 16; f++) begin
      step(1);
      irq_force_inputs = 4'(f);
      for (int i = 3; i >= 0; i--)
        if (f[i])
          p = 3'(i + 1);
      step(3);
      xfer(1'b0, 8'h3C, 4'h2, {16'h0, 5'h0, p, 8'h00});
      check({29'h0, irq_pin_value}, {29'h0, p});
    end
    step(1);
    irq_force_inputs = 4'h0;
    tie_all_irq_ctrl = 1'b1;
    step(3);
    check({31'h0, force_first_irq_line}, 32'h1);
    xfer(1'b0, 8'h3C, 4'h2, 32'h0000_0100);
    step(1);
    tie_all_irq_ctrl = 1'b0;
    step(3);
    check({31'h0, force_first_irq_line}, 32'h0);
    xfer(1'b0, 8'h3C, 4'h2, 32'h0000_0400);
    // all four control settings of the capabilities word
    for (int m = 0; m < 4; m++) begin
      step(1);
      {d3cold_enable, pm_revision_select} = 2'(m);
      step(2);
      xfer(1'b0, 8'h44, 4'hC, {pm(m[1], m[0]), 16'h0});
    end
    step(1);
    eeprom_load = 1'b1;
    eeprom_min_grant = 8'hA5;
    eeprom_max_latency = 8'h5A;
    step(1);
    eeprom_load = 1'b0;
    eeprom_min_grant = 8'h00;
    eeprom_max_latency = 8'h00;
    xfer(1'b0, 8'h3C, 4'hE, 32'h5AA5_0400);
    // writes are acked, return zero and leave everything as it was
    xfer(1'b1, 8'h3C, 4'hF, 32'h0);
    xfer(1'b1, 8'h44, 4'hF, 32'h0);
    xfer(1'b0, 8'h3C, 4'hF, 32'h5AA5_0400);
    xfer(1'b0, 8'h44, 4'hF, {pm(1'b1, 1'b1), 16'h0001});
    xfer(1'b0, 8'h40, 4'hF, 32'h0);
    // a mid-run reset must bring the loaded latency bytes back to zero
    step(1);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    xfer(1'b0, 8'h3C, 4'h4, 32'h0000_0000);
    xfer(1'b0, 8'h3C, 4'h8, 32'h0000_0000);
    xfer(1'b0, 8'h44, 4'hF, {pm(1'b1, 1'b1), 16'h0001});
    complete_run();
  end
endmodule : smartcard_pci_config_tail_regs_tb
